/* File: hw/pwe_pkg.sv */
// Purpose: shared constants and types of the programmable waveform engine
// Assumes: 16-bit APB byte addresses, 32-bit APB data
// Notes: register offsets, field positions, reset values, state codes
package pwe_pkg;
	// waveform storage window and register offsets
	localparam logic [15:0] STORE_BASE = 16'hE400;
	localparam logic [15:0] STORE_LAST = 16'hE47F;
	localparam logic [15:0] IDLECS_ADDR = 16'hE480;
	localparam logic [15:0] TRIG_ADDR = 16'hE484;
	localparam logic [15:0] CTLCFG_ADDR = 16'hE488;
	localparam logic [15:0] IDLECTL_ADDR = 16'hE48C;
	localparam logic [15:0] WFSEL_ADDR = 16'hE490;
	localparam logic [15:0] ABORT_ADDR = 16'hE494;
	localparam logic [15:0] INTERFACE_CONFIG_SELECT_ADDR = 16'hE498;
	localparam logic [15:0] READY_ADDR = 16'hE49C;
	localparam logic [15:0] TCOUNT_ADDR = 16'hE4A0;
	localparam logic [15:0] ADDR_ADDR = 16'hE4A4;
	// field positions
	localparam int DONE_BIT = 7;
	localparam int IDLE_BUS_DRIVE_BIT = 0;
	localparam int TRI_BIT = 7;
	localparam int INTERNAL_READY_FLAG_BIT = 0;
	// reset values and waveform mode select code
	localparam logic [7:0] IDLECTL_RST = 8'hFF;
	localparam logic [7:0] CTLCFG_RST = 8'h00;
	localparam logic [7:0] WFSEL_RST = 8'hE4;
	localparam logic [1:0] INTERFACE_CONFIG_SELECT_RST = 2'h0;
	localparam logic [1:0] WAVE_MODE = 2'h2;
	// state numbers and hold length
	localparam logic [2:0] IDLE_ST = 3'h7;
	localparam logic [2:0] LAST_ST = 3'h6;
	localparam logic [8:0] LEN_ZERO_CYCLES = 9'h100;
	// instruction fields: opcode bits, branch byte, logic byte
	localparam int OP_DP = 0;
	localparam int OP_DATA = 1;
	localparam int OP_NEXT = 2;
	localparam int OP_INCAD = 3;
	localparam int OP_GINT = 4;
	localparam int BR_REEXEC = 7;
	localparam logic [1:0] LF_AND = 2'h0;
	localparam logic [1:0] LF_OR = 2'h1;
	localparam logic [1:0] LF_XOR = 2'h2;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] lfn;
		logic [7:0] op;
		logic [7:0] lenbr;
	} pwe_instr_t;
	typedef struct packed {
		logic [5:0] lvl;
		logic [5:0] oe;
	} pwe_ctl_t;
	localparam pwe_ctl_t CTL_RST = '{lvl: 6'h3F, oe: 6'h3F};
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b000,
		ENG_ARM = 3'b001,
		ENG_FETCH = 3'b010,
		ENG_APPLY = 3'b011,
		ENG_RUN = 3'b100
	} pwe_eng_t;
endpackage

/* File: hw/pwe_wave_mem.sv */
// Purpose: waveform descriptor storage, bus port with byte lanes
// Assumes: one clock, registered read data on both ports
// Notes: port b is read only and feeds the engine
`timescale 1ns/10ps
`default_nettype none
module pwe_wave_mem #(
	parameter int AW = 5,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic [AW-1:0] a_addr,
	input wire logic a_we,
	input wire logic [DW/8-1:0] a_be,
	input wire logic [DW-1:0] a_wdata,
	output logic [DW-1:0] a_rdata,
	input wire logic [AW-1:0] b_addr,
	output logic [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	if (DW % 8 != 0) begin : g_chk
		$error("data width must be whole bytes");
	end

	for (genvar i = 0; i < DW/8; i++) begin : g_lane
		always_ff @(posedge clk) begin
			if (a_we && a_be[i]) begin
				mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8]; // [RULE9]
			end
		end
	end

	always_ff @(posedge clk) begin
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
	end
endmodule
`default_nettype wire

/* File: hw/pwe_engine.sv */
// Purpose: programmable waveform engine with APB register access
// Assumes: interface_clock and pins are asynchronous to sys_clk
// Notes: engine steps on sampled rising edges of interface_clock
// What this block does
// [RULE1] descriptors hold up to seven states; run exactly those defined
// [RULE2] each state drives controls, data bus, increments address, fifo, irq
// [RULE3] decision state combines two selected terms by and/or/xor, branches
// [RULE4] plain state holds a programmed 1 to 256 interface clocks
// [RULE5] 128 bytes of waveform storage from 0xE400 to 0xE47F
// [RULE6] software loads configuration and storage before any transfer
// [RULE7] storage reachable only while interface select holds 10
// [RULE8] software writes storage only while done reads 1
// [RULE9] storage takes single byte updates
// [RULE10] four descriptors, remappable to the four transfer types
// [RULE11] each state is one 32-bit instruction
// [RULE12] state changes only on interface clock rising edge
// [RULE13] states S0 to S6 programmable, S7 idle ends the waveform
// [RULE14] every descriptor branches to idle somewhere
// [RULE15] one waveform at a time; done is bit 7 of two registers
// [RULE16] done reads 0 while busy, 1 in idle
// [RULE17] only the abort register is writable while busy; it ends waveform
// [RULE18] idle data bus floats unless idle drive bit holds last value
// [RULE19] tristate mode 0: idle levels bits 5:0 set controls, always on
// [RULE20] tristate mode 0: config bit 1 makes a control open drain
// [RULE21] tristate mode 1: idle bits 7:4 enables, 3:0 levels, lines 0-3
// [RULE22] tristate mode is config bit 7; lines 4 and 5 then unavailable
// [RULE23] abort enters idle, applies idle levels, sets done
`timescale 1ns/10ps
`default_nettype none
module pwe_engine #(
	parameter int DATA_W = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic interface_clock,
	input wire logic [4:0] ready_pins,
	input wire logic fifo_flag,
	input wire logic [DATA_W-1:0] fifo_wdata,
	input wire logic [DATA_W-1:0] fifo_data_bus_i,
	output logic [DATA_W-1:0] fifo_data_bus_o,
	output logic fifo_data_bus_oe,
	output logic [5:0] control_outputs_o,
	output logic [5:0] control_outputs_oe,
	output logic [8:0] engine_address_bus,
	output logic fifo_advance,
	output logic [DATA_W-1:0] read_data,
	output logic read_strobe,
	output logic waveform_interrupt,
	output logic waveform_done_interrupt,
	output logic [2:0] engine_state
);
	if (DATA_W != 8 && DATA_W != 16) begin : g_chk
		$error("data bus must be 8 or 16 bits");
	end

	logic interface_clock_s1, interface_clock_s2, interface_clock_s3, interface_clock_rise;
	logic [4:0] rdy_s1, rdy_s2;
	logic [DATA_W-1:0] fd_s1, fd_s2;
	logic [31:0] prdata_q, rd_c, mem_a;
	logic pready_q, pslverr_q, hit_c, err_c;
	logic idle_bus_drive_q, internal_ready_flag_q, done_q;
	logic [7:0] ctlcfg_q, idlectl_q, wfsel_q;
	logic [1:0] interface_config_select_q, xfer_q;
	logic [15:0] tcount_q;
	logic [8:0] addr_q, cnt_q;
	logic [DATA_W-1:0] fd_o_q, rd_data_q;
	logic fd_oe_q, fifo_adv_q, wf_int_q, done_int_q, rd_strobe_q;
	pwe_pkg::pwe_ctl_t ctl_q;
	pwe_pkg::pwe_eng_t eng_q;
	pwe_pkg::pwe_instr_t instr_q, mem_b, task_ins;
	logic [2:0] st_q, nxt_c;
	logic [1:0] desc_q;
	logic [7:0] terms_c;
	logic ta_c, tb_c, res_c, leave_c, loop_task_c, task_c, run_edge;
	logic [5:0] idle_lvl_w;

	// two-flop synchronisers, edge found past the second stage
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			interface_clock_s1 <= 1'b0;
			interface_clock_s2 <= 1'b0;
			interface_clock_s3 <= 1'b0;
			rdy_s1 <= 5'h00;
			rdy_s2 <= 5'h00;
			fd_s1 <= '0;
			fd_s2 <= '0;
		end else begin
			interface_clock_s1 <= interface_clock;
			interface_clock_s2 <= interface_clock_s1;
			interface_clock_s3 <= interface_clock_s2;
			rdy_s1 <= ready_pins;
			rdy_s2 <= rdy_s1;
			fd_s1 <= fifo_data_bus_i;
			fd_s2 <= fd_s1;
		end
	end
	assign interface_clock_rise = interface_clock_s2 & ~interface_clock_s3; // [RULE12]

	// apb decode
	wire busy = eng_q != pwe_pkg::ENG_IDLE;
	wire mode_ok = interface_config_select_q == pwe_pkg::WAVE_MODE;
	wire store_hit = paddr >= pwe_pkg::STORE_BASE &&
		paddr <= pwe_pkg::STORE_LAST; // [RULE5]
	wire abort_hit = paddr == pwe_pkg::ABORT_ADDR;
	wire acc_done = psel & penable & pready_q;
	wire wr_c = acc_done & pwrite & ~pslverr_q;
	wire abort_c = acc_done & pwrite & abort_hit; // [RULE17]
	wire start_c = wr_c & (paddr == pwe_pkg::TRIG_ADDR);
	assign idle_lvl_w = idlectl_q[5:0];

	always_comb begin
		rd_c = 32'h0000_0000;
		hit_c = 1'b1;
		if (store_hit) begin
			rd_c = mode_ok ? mem_a : 32'h0000_0000;
		end else begin
			unique case (paddr)
				pwe_pkg::IDLECS_ADDR: rd_c[7:0] = {done_q, 6'h00, idle_bus_drive_q};
				pwe_pkg::TRIG_ADDR: rd_c[7:0] = {done_q, 5'h00, xfer_q}; // [RULE15]
				pwe_pkg::CTLCFG_ADDR: rd_c[7:0] = ctlcfg_q;
				pwe_pkg::IDLECTL_ADDR: rd_c[7:0] = idlectl_q;
				pwe_pkg::WFSEL_ADDR: rd_c[7:0] = wfsel_q;
				pwe_pkg::ABORT_ADDR: rd_c = 32'h0000_0000;
				pwe_pkg::INTERFACE_CONFIG_SELECT_ADDR: rd_c[1:0] = interface_config_select_q;
				pwe_pkg::READY_ADDR: rd_c[0] = internal_ready_flag_q;
				pwe_pkg::TCOUNT_ADDR: rd_c[15:0] = tcount_q;
				pwe_pkg::ADDR_ADDR: rd_c[8:0] = addr_q;
				default: hit_c = 1'b0;
			endcase
		end
		err_c = ~hit_c | (store_hit & ~mode_ok) // [RULE7]
			| (pwrite & busy & ~abort_hit); // [RULE8] [RULE17]
	end

	// one wait cycle: memory read data is registered
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel && penable && !pready_q) begin
				pslverr_q <= err_c;
				prdata_q <= pwrite ? 32'h0000_0000 : rd_c;
			end
		end
	end

	pwe_wave_mem #(.AW(5), .DW(32)) u_mem (
		.clk(sys_clk),
		.a_addr(paddr[6:2]),
		.a_we(wr_c & store_hit), // [RULE9]
		.a_be(pstrb),
		.a_wdata(pwdata),
		.a_rdata(mem_a),
		.b_addr({desc_q, st_q}), // [RULE10] [RULE11]
		.b_rdata(mem_b)
	);

	// configuration registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			idle_bus_drive_q <= 1'b0;
			ctlcfg_q <= pwe_pkg::CTLCFG_RST;
			idlectl_q <= pwe_pkg::IDLECTL_RST;
			wfsel_q <= pwe_pkg::WFSEL_RST;
			interface_config_select_q <= pwe_pkg::INTERFACE_CONFIG_SELECT_RST;
			internal_ready_flag_q <= 1'b0;
			xfer_q <= 2'h0;
		end else if (wr_c) begin
			unique case (paddr)
				pwe_pkg::IDLECS_ADDR: idle_bus_drive_q <= pwdata[pwe_pkg::IDLE_BUS_DRIVE_BIT];
				pwe_pkg::CTLCFG_ADDR: ctlcfg_q <= pwdata[7:0]; // [RULE22]
				pwe_pkg::IDLECTL_ADDR: idlectl_q <= pwdata[7:0];
				pwe_pkg::WFSEL_ADDR: wfsel_q <= pwdata[7:0]; // [RULE10]
				pwe_pkg::INTERFACE_CONFIG_SELECT_ADDR: interface_config_select_q <= pwdata[1:0];
				pwe_pkg::READY_ADDR: internal_ready_flag_q <= pwdata[pwe_pkg::INTERNAL_READY_FLAG_BIT];
				pwe_pkg::TRIG_ADDR: xfer_q <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// decision terms and next state
	assign terms_c = {internal_ready_flag_q, fifo_flag, tcount_q == 16'h0000, rdy_s2};
	always_comb begin
		ta_c = terms_c[instr_q.lfn[5:3]]; // [RULE3]
		tb_c = terms_c[instr_q.lfn[2:0]];
		unique case (instr_q.lfn[7:6])
			pwe_pkg::LF_AND: res_c = ta_c & tb_c;
			pwe_pkg::LF_OR: res_c = ta_c | tb_c;
			pwe_pkg::LF_XOR: res_c = ta_c ^ tb_c;
			default: res_c = ta_c & tb_c;
		endcase
		loop_task_c = 1'b0;
		if (instr_q.op[pwe_pkg::OP_DP]) begin
			nxt_c = res_c ? instr_q.lenbr[5:3] : instr_q.lenbr[2:0]; // [RULE3]
			leave_c = nxt_c != st_q;
			loop_task_c = !leave_c && instr_q.lenbr[pwe_pkg::BR_REEXEC];
		end else begin
			nxt_c = st_q + 3'h1; // [RULE1]
			leave_c = cnt_q == 9'h001; // [RULE4]
		end
	end
	assign run_edge = (eng_q == pwe_pkg::ENG_RUN) & interface_clock_rise;

	// sequencer
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			eng_q <= pwe_pkg::ENG_IDLE;
			st_q <= pwe_pkg::IDLE_ST;
			cnt_q <= 9'h001;
			desc_q <= 2'h0;
			instr_q <= '0;
			done_q <= 1'b1;
		end else if (abort_c) begin
			eng_q <= pwe_pkg::ENG_IDLE; // [RULE23]
			st_q <= pwe_pkg::IDLE_ST;
			done_q <= 1'b1;
		end else begin
			unique case (eng_q)
				pwe_pkg::ENG_IDLE: if (start_c) begin
					desc_q <= wfsel_q[{pwdata[1:0], 1'b0} +: 2]; // [RULE10]
					st_q <= 3'h0;
					done_q <= 1'b0; // [RULE16]
					eng_q <= pwe_pkg::ENG_ARM;
				end
				pwe_pkg::ENG_ARM: if (interface_clock_rise) begin
					eng_q <= pwe_pkg::ENG_FETCH; // [RULE12]
				end
				pwe_pkg::ENG_FETCH: eng_q <= pwe_pkg::ENG_APPLY;
				pwe_pkg::ENG_APPLY: begin
					instr_q <= mem_b; // [RULE11]
					cnt_q <= mem_b.lenbr == 8'h00 ? pwe_pkg::LEN_ZERO_CYCLES
						: {1'b0, mem_b.lenbr}; // [RULE4]
					eng_q <= pwe_pkg::ENG_RUN;
				end
				pwe_pkg::ENG_RUN: if (interface_clock_rise) begin
					if (leave_c) begin
						st_q <= nxt_c;
						if (nxt_c == pwe_pkg::IDLE_ST) begin
							eng_q <= pwe_pkg::ENG_IDLE; // [RULE13] [RULE14]
							done_q <= 1'b1; // [RULE16]
						end else begin
							eng_q <= pwe_pkg::ENG_FETCH;
						end
					end else if (!instr_q.op[pwe_pkg::OP_DP]) begin
						cnt_q <= cnt_q - 9'h001; // [RULE4]
					end
				end
				default: eng_q <= pwe_pkg::ENG_IDLE;
			endcase
		end
	end

	// state tasks: once on entry, again per loop when re-execute is set
	assign task_c = (eng_q == pwe_pkg::ENG_APPLY) | (run_edge & loop_task_c);
	assign task_ins = (eng_q == pwe_pkg::ENG_APPLY) ? mem_b : instr_q;
	wire do_data = task_c & task_ins.op[pwe_pkg::OP_DATA];
	wire do_next = task_c & task_ins.op[pwe_pkg::OP_NEXT];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fifo_adv_q <= 1'b0;
			wf_int_q <= 1'b0;
			rd_strobe_q <= 1'b0;
			rd_data_q <= '0;
			fd_o_q <= '0;
		end else begin
			fifo_adv_q <= do_next; // [RULE2]
			wf_int_q <= task_c & task_ins.op[pwe_pkg::OP_GINT];
			rd_strobe_q <= do_data & xfer_q[0];
			if (do_data && xfer_q[0]) begin
				rd_data_q <= fd_s2; // [RULE2]
			end
			if (do_data && !xfer_q[0]) begin
				fd_o_q <= fifo_wdata; // [RULE2]
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			addr_q <= 9'h000;
		end else if (wr_c && paddr == pwe_pkg::ADDR_ADDR) begin
			addr_q <= pwdata[8:0];
		end else if (task_c && task_ins.op[pwe_pkg::OP_INCAD]) begin
			addr_q <= addr_q + 9'h001; // [RULE2]
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tcount_q <= 16'h0000;
		end else if (wr_c && paddr == pwe_pkg::TCOUNT_ADDR) begin
			tcount_q <= pwdata[15:0];
		end else if (do_next && tcount_q != 16'h0000) begin
			tcount_q <= tcount_q - 16'h0001;
		end
	end

	function automatic pwe_pkg::pwe_ctl_t ctl_map(input logic [7:0] v,
		input logic [7:0] cfg);
		pwe_pkg::pwe_ctl_t c;
		if (cfg[pwe_pkg::TRI_BIT]) begin
			c.lvl = {2'b00, v[3:0]}; // [RULE21] [RULE22]
			c.oe = {2'b00, v[7:4]};
		end else begin
			c.lvl = v[5:0] & ~cfg[5:0]; // [RULE19] [RULE20]
			c.oe = ~cfg[5:0] | ~v[5:0];
		end
		return c;
	endfunction

	// pin drive: idle levels from registers, state levels from instruction
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctl_q <= pwe_pkg::CTL_RST;
			fd_oe_q <= 1'b0;
		end else if (eng_q == pwe_pkg::ENG_IDLE) begin
			ctl_q <= ctl_map(idlectl_q, ctlcfg_q); // [RULE19] [RULE21]
			fd_oe_q <= idle_bus_drive_q; // [RULE18]
		end else if (eng_q == pwe_pkg::ENG_APPLY) begin
			ctl_q <= ctl_map(mem_b.out, ctlcfg_q); // [RULE2]
			fd_oe_q <= mem_b.op[pwe_pkg::OP_DATA] & ~xfer_q[0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			done_int_q <= 1'b0;
		end else begin
			done_int_q <= (abort_c & busy) |
				(run_edge & leave_c & (nxt_c == pwe_pkg::IDLE_ST)); // [RULE15]
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fifo_data_bus_o = fd_o_q;
	assign fifo_data_bus_oe = fd_oe_q;
	assign control_outputs_o = ctl_q.lvl;
	assign control_outputs_oe = ctl_q.oe;
	assign engine_address_bus = addr_q;
	assign fifo_advance = fifo_adv_q;
	assign read_data = rd_data_q;
	assign read_strobe = rd_strobe_q;
	assign waveform_interrupt = wf_int_q;
	assign waveform_done_interrupt = done_int_q;
	assign engine_state = st_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_done_tracks_idle: assert property ( // [RULE16]
		done_q == (eng_q == pwe_pkg::ENG_IDLE))
		else $error("done bit disagrees with engine state");
	a_abort_forces_idle: assert property ( // [RULE23]
		abort_c |=> eng_q == pwe_pkg::ENG_IDLE && done_q &&
		st_q == pwe_pkg::IDLE_ST ##1 ctl_q == ctl_map(idlectl_q, ctlcfg_q))
		else $error("abort did not return engine to idle");
	a_store_mode_gate: assert property ( // [RULE7]
		(acc_done && store_hit && !mode_ok) |-> pslverr_q)
		else $error("storage access outside waveform mode not refused");
	a_busy_write_gate: assert property ( // [RULE17]
		(acc_done && pwrite && busy && !abort_hit) |-> pslverr_q)
		else $error("write while busy not refused");
	a_ndp_holds: assert property ( // [RULE4]
		(run_edge && !instr_q.op[pwe_pkg::OP_DP] && cnt_q > 9'h001 &&
		!abort_c) |=> eng_q == pwe_pkg::ENG_RUN && $stable(st_q) &&
		cnt_q == $past(cnt_q) - 9'h001)
		else $error("plain state left before its length");
	a_step_on_edge: assert property ( // [RULE12]
		(eng_q == pwe_pkg::ENG_RUN && !interface_clock_rise && !abort_c) |=>
		eng_q == pwe_pkg::ENG_RUN && $stable(st_q))
		else $error("state changed without interface clock edge");
	a_dp_branch_one: assert property ( // [RULE3]
		(run_edge && instr_q.op[pwe_pkg::OP_DP] && res_c && !abort_c) |=>
		st_q == $past(instr_q.lenbr[5:3]))
		else $error("decision branch on true result wrong");
	a_last_state_exit: assert property ( // [RULE13]
		(run_edge && !instr_q.op[pwe_pkg::OP_DP] && !abort_c &&
		st_q == pwe_pkg::LAST_ST && cnt_q == 9'h001) |=>
		eng_q == pwe_pkg::ENG_IDLE && done_q ##1 done_int_q == 1'b0)
		else $error("last state did not fall into idle");
	a_idle_bus_float: assert property ( // [RULE18]
		(eng_q == pwe_pkg::ENG_IDLE && !idle_bus_drive_q) |=> !fd_oe_q)
		else $error("data bus driven in idle without idle drive");
	a_idle_ctl_push: assert property ( // [RULE19]
		(eng_q == pwe_pkg::ENG_IDLE && !ctlcfg_q[pwe_pkg::TRI_BIT] &&
		ctlcfg_q[5:0] == 6'h00) |=> ctl_q.oe == 6'h3F &&
		ctl_q.lvl == $past(idle_lvl_w))
		else $error("idle control levels not applied");
	a_idle_ctl_tri: assert property ( // [RULE21]
		(eng_q == pwe_pkg::ENG_IDLE && ctlcfg_q[pwe_pkg::TRI_BIT]) |=>
		ctl_q.oe[5:4] == 2'b00 && ctl_q.lvl[5:4] == 2'b00)
		else $error("lines 4 and 5 active in tristate mode");
endmodule
`default_nettype wire

/* File: dv/pwe_peri_model.sv */
// Purpose: far-side peripheral for the waveform engine pins
// Assumes: interface clock is a free running 125 ns source
// Notes: peripheral drives the inverse of the engine value when released
`timescale 1ns/10ps
`default_nettype none
module pwe_peri_model (
	input wire logic [4:0] rdy_cmd,
	input wire logic [7:0] bus_o,
	input wire logic bus_oe,
	output logic interface_clock,
	output logic [4:0] ready_pins,
	output logic [7:0] bus_i
);
	initial begin
		interface_clock = 1'b0;
		ready_pins = 5'h00;
	end
	// clock runs free, as an external interface clock source does
	always #62.5 interface_clock = ~interface_clock;
	// ready lines change only with the interface clock
	always @(posedge interface_clock) begin
		ready_pins <= rdy_cmd;
	end
	// released bus: peripheral answers with the inverse of the last value
	assign bus_i = bus_oe ? bus_o : ~bus_o;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the waveform engine
// Assumes: APB master tasks, one wait cycle per access from the slave
// Notes: three waveforms run from descriptor 0, one ends by abort
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic ifc, fd_oe, adv, rd_stb, wirq, dirq;
	logic [4:0] rdy_pins, rdy_cmd;
	logic [7:0] fd_i, fd_o, rdat;
	logic [5:0] ctl_o, ctl_oe;
	logic [8:0] addr;
	logic [2:0] st;
	int error_cnt, checked, done_cnt, adv_cnt, s0_cnt, bad_cnt;
	int rd_cnt, wirq_cnt;
	pwe_engine pwe_engine_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.interface_clock(ifc), .ready_pins(rdy_pins), .fifo_flag(1'b0),
		.fifo_wdata(8'hA5), .fifo_data_bus_i(fd_i), .fifo_data_bus_o(fd_o),
		.fifo_data_bus_oe(fd_oe), .control_outputs_o(ctl_o),
		.control_outputs_oe(ctl_oe), .engine_address_bus(addr),
		.fifo_advance(adv), .read_data(rdat), .read_strobe(rd_stb),
		.waveform_interrupt(wirq), .waveform_done_interrupt(dirq),
		.engine_state(st));
	pwe_peri_model pwe_peri_model_inst (.rdy_cmd(rdy_cmd),
		.bus_o(fd_o), .bus_oe(fd_oe), .interface_clock(ifc),
		.ready_pins(rdy_pins), .bus_i(fd_i));
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (rstn) begin
			done_cnt <= done_cnt + int'(dirq);
			adv_cnt <= adv_cnt + int'(adv);
			rd_cnt <= rd_cnt + int'(rd_stb);
			wirq_cnt <= wirq_cnt + int'(wirq);
			s0_cnt <= s0_cnt + int'(st == 3'h0);
			bad_cnt <= bad_cnt + int'(st != 3'h0 && st != 3'h1 && st != 3'h7);
		end
	end
	task automatic final_report();
		$display("mismatches %0d, comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(pready), 32'h0000_0001);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
		chk(32'(e), 32'(ee));
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] ed,
		input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
		chk(32'(e), 32'(ee));
		chk(r, ed);
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim);
		int n;
		n = 0;
		while (st !== s && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(st), 32'(s));
	endtask
	// compares driven levels only: released lines carry no level
	task automatic wait_ctl(input logic [5:0] eo, input logic [5:0] eoe);
		int n;
		n = 0;
		while ({ctl_o & ctl_oe, ctl_oe} !== {eo, eoe} && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'({ctl_o & ctl_oe, ctl_oe}), 32'({eo, eoe}));
	endtask
	initial begin
		#200_000;
		error_cnt++;
		final_report();
	end
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		rdy_cmd = 5'h00;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		wait_ctl(6'h3F, 6'h3F);
		chk(32'({fd_oe, st, addr}), 32'h0000_0E00);
		rd(pwe_pkg::IDLECS_ADDR, 32'h0000_0080, 1'b0);
		rd(pwe_pkg::CTLCFG_ADDR, 32'h0000_0000, 1'b0);
		rd(pwe_pkg::IDLECTL_ADDR, 32'h0000_00FF, 1'b0);
		rd(pwe_pkg::WFSEL_ADDR, 32'h0000_00E4, 1'b0);
		rd(pwe_pkg::INTERFACE_CONFIG_SELECT_ADDR, 32'h0000_0000, 1'b0);
		wr(pwe_pkg::STORE_BASE, 32'h1234_5678, 4'hF, 1'b1);
		rd(pwe_pkg::STORE_BASE, 32'h0000_0000, 1'b1);
		wr(16'hE4FC, 32'h0000_0001, 4'hF, 1'b1);
		// config and storage loaded before any trigger
		wr(pwe_pkg::INTERFACE_CONFIG_SELECT_ADDR, 32'h0000_0002, 4'hF, 1'b0);
		wr(16'hE47C, 32'h1122_3344, 4'hF, 1'b0);
		wr(16'hE47C, 32'h00AA_0000, 4'h4, 1'b0);
		rd(16'hE47C, 32'h11AA_3344, 1'b0);
		wr(pwe_pkg::IDLECTL_ADDR, 32'h0000_0015, 4'hF, 1'b0);
		wait_ctl(6'h15, 6'h3F);
		wr(pwe_pkg::CTLCFG_ADDR, 32'h0000_0001, 4'hF, 1'b0);
		wait_ctl(6'h14, 6'h3E);
		wr(pwe_pkg::CTLCFG_ADDR, 32'h0000_0080, 4'hF, 1'b0);
		wr(pwe_pkg::IDLECTL_ADDR, 32'h0000_00F5, 4'hF, 1'b0);
		wait_ctl(6'h05, 6'h0F);
		wr(pwe_pkg::CTLCFG_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		wr(pwe_pkg::IDLECTL_ADDR, 32'h0000_003F, 4'hF, 1'b0);
		// s0: hold 2 clocks, drive data; s1: wait on ready 0, then idle
		wr(16'hE400, 32'h0100_0202, 4'hF, 1'b0);
		wr(16'hE404, 32'h0200_1D39, 4'hF, 1'b0);
		wr(pwe_pkg::IDLECS_ADDR, 32'h0000_0001, 4'hF, 1'b0);
		wr(pwe_pkg::READY_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		wr(pwe_pkg::TRIG_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		rd(pwe_pkg::IDLECS_ADDR, 32'h0000_0001, 1'b0);
		wr(pwe_pkg::IDLECTL_ADDR, 32'h0000_0000, 4'hF, 1'b1);
		wait_st(3'h0, 200);
		wait_ctl(6'h01, 6'h3F);
		chk(32'({fd_oe, fd_o}), 32'h0000_01A5);
		wait_st(3'h1, 200);
		wait_ctl(6'h02, 6'h3F);
		repeat (100) @(posedge sys_clk);
		chk(32'(st), 32'h0000_0001);
		rdy_cmd <= 5'h01;
		wait_st(3'h7, 200);
		wait_ctl(6'h3F, 6'h3F);
		chk(32'({fd_oe, fd_o}), 32'h0000_01A5);
		// two interface clocks plus up to one clock of start latency
		chk(32'(s0_cnt >= 26 && s0_cnt <= 40), 32'h0000_0001);
		chk(32'(done_cnt), 32'h0000_0001);
		chk(32'(adv_cnt), 32'h0000_0001);
		chk(32'(addr), 32'h0000_0001);
		rd(pwe_pkg::IDLECS_ADDR, 32'h0000_0081, 1'b0);
		rd(pwe_pkg::TRIG_ADDR, 32'h0000_0080, 1'b0);
		rdy_cmd <= 5'h00;
		wr(pwe_pkg::IDLECS_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		wr(pwe_pkg::TRIG_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		wait_st(3'h1, 200);
		wr(pwe_pkg::TRIG_ADDR, 32'h0000_0001, 4'hF, 1'b1);
		wr(pwe_pkg::ABORT_ADDR, 32'h0000_0000, 4'hF, 1'b0);
		wait_st(3'h7, 2);
		wait_ctl(6'h3F, 6'h3F);
		chk(32'(fd_oe), 32'h0000_0000);
		chk(32'(done_cnt), 32'h0000_0002);
		chk(32'(addr), 32'h0000_0002);
		rd(pwe_pkg::IDLECS_ADDR, 32'h0000_0080, 1'b0);
		// descriptor change by one byte: s1 becomes ready 0 xor internal
		wr(16'hE404, 32'h0087_0000, 4'h4, 1'b0);
		wr(pwe_pkg::READY_ADDR, 32'h0000_0001, 4'hF, 1'b0);
		wr(pwe_pkg::WFSEL_ADDR, 32'h0000_0004, 4'hF, 1'b0);
		rdy_cmd <= 5'h01;
		wr(pwe_pkg::TRIG_ADDR, 32'h0000_0003, 4'hF, 1'b0);
		wait_st(3'h1, 200);
		repeat (100) @(posedge sys_clk);
		chk(32'(st), 32'h0000_0001);
		rdy_cmd <= 5'h00;
		wait_st(3'h7, 200);
		rd(pwe_pkg::TRIG_ADDR, 32'h0000_0083, 1'b0);
		chk(32'(done_cnt), 32'h0000_0003);
		chk(32'(addr), 32'h0000_0003);
		chk(32'(bad_cnt), 32'h0000_0000);
		chk(32'(rdat), 32'h0000_005A);
		chk(32'(rd_cnt), 32'h0000_0001);
		chk(32'(wirq_cnt), 32'h0000_0003);
		final_report();
	end
endmodule
`default_nettype wire
